/* rtl/supervisor_cfg.svh */
// Register offsets, field positions, reset values and widths for the output supervisor.
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH
`define OFS_CTRL      12'h000
`define OFS_VPROT     12'h004
`define OFS_APROT     12'h008
`define OFS_WPROT     12'h00C
`define OFS_LOWV_THR  12'h010
`define OFS_HIGHV_THR 12'h014
`define OFS_LOWA_THR  12'h018
`define OFS_HIGHA_THR 12'h01C
`define OFS_HIGHW_THR 12'h020
`define OFS_ACTIONS   12'h024
`define OFS_STATUS    12'h028
`define OFS_ACK       12'h02C
`define OFS_PROFILE   12'h030
`define CTRL_OUT_ON      0
`define CTRL_SOUND       1
`define CTRL_PF_RESUME   2
`define CTRL_OT_RESUME   3
`define CTRL_REQ_OFF     4
`define ALM_VPROT        0
`define ALM_APROT        1
`define ALM_WPROT        2
`define ALM_PF           3
`define ALM_OT           4
`define NUM_ALM          5
`define NUM_EVT          5
`define EVT_LOWV         0
`define EVT_HIGHV        1
`define EVT_LOWA         2
`define EVT_HIGHA        3
`define EVT_HIGHW        4
`define ST_EVT_BASE      8
`define ST_OUT_BIT       16
`define ST_REJ_BIT       17
`define PROT_PCT         110
`define PCT_DIV          100
`define ZERO32           32'h0000_0000
`endif

/* rtl/supervisor_pkg.sv */
// Types shared by the output supervisor.
package supervisor_pkg;
  typedef enum logic [1:0] {
    ACT_NONE    = 2'b00,
    ACT_SIGNAL  = 2'b01,
    ACT_WARNING = 2'b10,
    ACT_ALARM   = 2'b11
  } action_e;
endpackage

/* rtl/output_alarm_event_supervisor.sv */
// Output alarm and event supervisor for a DC supply, with an APB register slave.
// How it works
// - Action none disables the event entirely.
// - Signal gives status text; warning adds popup.
// - Alarm action: status, alarm popup, output off.
// - Alarm events beep only when sound enabled.
// - Protection alarms switch output off immediately.
// - Acknowledge accepted only once cause cleared.
// - Supply-fail and overheat may auto-resume output.
// - Alarm indication stays until acknowledged.
// - Voltage reaching protect threshold trips alarm.
// - Current reaching protect threshold trips alarm.
// - Power reaching protect threshold trips alarm.
// - Supply fault input trips alarm, output off.
// - Overheat input trips alarm, output off.
// - Protect thresholds default to 110% nominal.
// - Settings change only while output off, except the supply-fail and overheat resume enables.
// - Events reset to action none, independent.
// - Events only while output on; alarms always.
// - Low/high voltage events against thresholds.
// - Low/high current events against thresholds.
// - High power event against its threshold.
// - Profile load replaces whole event configuration.
// - Combined status output for voltage, current and power protection alarms.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "supervisor_cfg.svh"

module output_alarm_event_supervisor #(
  parameter int W       = 16,
  parameter int NOM_V   = 16'h2000,
  parameter int NOM_A   = 16'h1000,
  parameter int NOM_W   = 16'h4000
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          sample_valid,
  input  wire logic [W-1:0]  meas_volt,
  input  wire logic [W-1:0]  meas_amp,
  input  wire logic [W-1:0]  meas_watt,
  input  wire logic          supply_fault,
  input  wire logic          overheat_fault,
  input  wire logic          profile_load,
  input  wire logic [W-1:0]  profile_thr [`NUM_EVT],
  input  wire logic [9:0]    profile_act,
  output logic               dc_output_on,
  output logic               status_text,
  output logic               warning_popup,
  output logic               alarm_popup,
  output logic               beep,
  output logic               combined_alarm
);

  localparam logic [W-1:0] VPROT_DEF = W'(NOM_V * `PROT_PCT / `PCT_DIV);
  localparam logic [W-1:0] APROT_DEF = W'(NOM_A * `PROT_PCT / `PCT_DIV);
  localparam logic [W-1:0] WPROT_DEF = W'(NOM_W * `PROT_PCT / `PCT_DIV);

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration and state registers.

  logic                 out_on_reg,   out_on_next;
  logic                 sound_reg,    sound_next;
  logic                 pf_res_reg,   pf_res_next;
  logic                 ot_res_reg,   ot_res_next;
  logic [W-1:0]         vprot_reg,    vprot_next;
  logic [W-1:0]         aprot_reg,    aprot_next;
  logic [W-1:0]         wprot_reg,    wprot_next;
  logic [W-1:0]         thr_reg [`NUM_EVT];
  logic [W-1:0]         thr_next [`NUM_EVT];
  supervisor_pkg::action_e act_reg [`NUM_EVT];
  supervisor_pkg::action_e act_next [`NUM_EVT];
  logic [`NUM_ALM-1:0]  alm_reg,      alm_next;
  logic [`NUM_EVT-1:0]  evt_reg,      evt_next;
  logic                 resume_reg,   resume_next;
  logic                 rej_reg,      rej_next;
  logic [`ALM_WPROT:`ALM_VPROT] level_reg, level_next;
  logic [31:0]          prdata_next;
  logic                 pready_next;
  logic                 pslverr_next;
  logic                 text_next, warn_next, apop_next, beep_next, comb_next;

  logic                 wr_acc;
  logic                 rd_acc;
  logic [`NUM_ALM-1:0]  cause;
  logic [`NUM_EVT-1:0]  evt_hit;
  logic [`NUM_EVT-1:0]  evt_alarm_hit;
  logic                 trip;

  assign wr_acc = psel && penable && pwrite && !pready;
  assign rd_acc = psel && penable && !pwrite && !pready;

  ////////////////////////////////////////////////////////////////////////////////
  // Live causes of each protection alarm and each event on this sample.

  always_comb begin
    cause                = '0;
    cause[`ALM_VPROT]    = sample_valid && (meas_volt >= vprot_reg);
    cause[`ALM_APROT]    = sample_valid && (meas_amp  >= aprot_reg);
    cause[`ALM_WPROT]    = sample_valid && (meas_watt >= wprot_reg);
    cause[`ALM_PF]       = supply_fault;
    cause[`ALM_OT]       = overheat_fault;
  end

  // Protection compares are held between samples, so an acknowledge sees the last result.
  always_comb begin
    level_next = level_reg;
    if (sample_valid) begin
      level_next = cause[`ALM_WPROT:`ALM_VPROT];
    end
  end

  always_comb begin
    evt_hit             = '0;
    evt_hit[`EVT_LOWV]  = meas_volt < thr_reg[`EVT_LOWV];
    evt_hit[`EVT_HIGHV] = meas_volt > thr_reg[`EVT_HIGHV];
    evt_hit[`EVT_LOWA]  = meas_amp  < thr_reg[`EVT_LOWA];
    evt_hit[`EVT_HIGHA] = meas_amp  > thr_reg[`EVT_HIGHA];
    evt_hit[`EVT_HIGHW] = meas_watt > thr_reg[`EVT_HIGHW];
  end

  genvar g;
  generate
    for (g = 0; g < `NUM_EVT; g++) begin : g_evt
      // Event alarms only qualify on a sample while the output is on and the event's action is alarm.
      assign evt_alarm_hit[g] = sample_valid && out_on_reg && evt_hit[g] &&
                                (act_reg[g] == supervisor_pkg::ACT_ALARM);
    end
  endgenerate

  assign trip = |cause || |evt_alarm_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic: APB writes, alarm latching, acknowledge and output control.

  always_comb begin
    logic [`NUM_ALM-1:0] ack_a;
    logic [`NUM_EVT-1:0] ack_e;
    logic                cfg_ok;
    ack_a        = '0;
    ack_e        = '0;
    cfg_ok       = !out_on_reg;
    out_on_next  = out_on_reg;
    sound_next   = sound_reg;
    pf_res_next  = pf_res_reg;
    ot_res_next  = ot_res_reg;
    vprot_next   = vprot_reg;
    aprot_next   = aprot_reg;
    wprot_next   = wprot_reg;
    thr_next     = thr_reg;
    act_next     = act_reg;
    resume_next  = resume_reg;
    rej_next     = rej_reg;
    pready_next  = psel && penable && !pready;
    pslverr_next = 1'b0;
    prdata_next  = `ZERO32;

    if (wr_acc) begin
      unique case (paddr)
        `OFS_CTRL: begin
          sound_next  = cfg_ok ? pwdata[`CTRL_SOUND] : sound_reg;
          pf_res_next = pwdata[`CTRL_PF_RESUME];
          ot_res_next = pwdata[`CTRL_OT_RESUME];
          if (pwdata[`CTRL_REQ_OFF]) begin
            out_on_next = 1'b0;
            resume_next = 1'b0;
          end else if (pwdata[`CTRL_OUT_ON] && alm_reg == '0) begin
            out_on_next = 1'b1;
          end
          rej_next    = !cfg_ok && (pwdata[`CTRL_SOUND] != sound_reg);
        end
        `OFS_VPROT:     if (cfg_ok) vprot_next = pwdata[W-1:0]; else rej_next = 1'b1;
        `OFS_APROT:     if (cfg_ok) aprot_next = pwdata[W-1:0]; else rej_next = 1'b1;
        `OFS_WPROT:     if (cfg_ok) wprot_next = pwdata[W-1:0]; else rej_next = 1'b1;
        `OFS_LOWV_THR:  if (cfg_ok) thr_next[`EVT_LOWV]  = pwdata[W-1:0]; else rej_next = 1'b1;
        `OFS_HIGHV_THR: if (cfg_ok) thr_next[`EVT_HIGHV] = pwdata[W-1:0]; else rej_next = 1'b1;
        `OFS_LOWA_THR:  if (cfg_ok) thr_next[`EVT_LOWA]  = pwdata[W-1:0]; else rej_next = 1'b1;
        `OFS_HIGHA_THR: if (cfg_ok) thr_next[`EVT_HIGHA] = pwdata[W-1:0]; else rej_next = 1'b1;
        `OFS_HIGHW_THR: if (cfg_ok) thr_next[`EVT_HIGHW] = pwdata[W-1:0]; else rej_next = 1'b1;
        `OFS_ACTIONS: begin
          if (cfg_ok) begin
            for (int i = 0; i < `NUM_EVT; i++) begin
              act_next[i] = supervisor_pkg::action_e'(pwdata[2*i +: 2]);
            end
          end else begin
            rej_next = 1'b1;
          end
        end
        `OFS_ACK: begin
          // Only alarms whose cause has gone may be cleared.
          ack_a = pwdata[`NUM_ALM-1:0] & ~(cause | `NUM_ALM'(level_reg));
          ack_e = pwdata[`ST_EVT_BASE +: `NUM_EVT] & ~evt_alarm_hit;
        end
        `OFS_STATUS, `OFS_PROFILE: ;
        default: pslverr_next = 1'b1;
      endcase
    end

    if (rd_acc) begin
      unique case (paddr)
        `OFS_CTRL: begin
          prdata_next[`CTRL_OUT_ON]    = out_on_reg;
          prdata_next[`CTRL_SOUND]     = sound_reg;
          prdata_next[`CTRL_PF_RESUME] = pf_res_reg;
          prdata_next[`CTRL_OT_RESUME] = ot_res_reg;
        end
        `OFS_VPROT:     prdata_next[W-1:0] = vprot_reg;
        `OFS_APROT:     prdata_next[W-1:0] = aprot_reg;
        `OFS_WPROT:     prdata_next[W-1:0] = wprot_reg;
        `OFS_LOWV_THR:  prdata_next[W-1:0] = thr_reg[`EVT_LOWV];
        `OFS_HIGHV_THR: prdata_next[W-1:0] = thr_reg[`EVT_HIGHV];
        `OFS_LOWA_THR:  prdata_next[W-1:0] = thr_reg[`EVT_LOWA];
        `OFS_HIGHA_THR: prdata_next[W-1:0] = thr_reg[`EVT_HIGHA];
        `OFS_HIGHW_THR: prdata_next[W-1:0] = thr_reg[`EVT_HIGHW];
        `OFS_ACTIONS: begin
          for (int i = 0; i < `NUM_EVT; i++) begin
            prdata_next[2*i +: 2] = act_reg[i];
          end
        end
        `OFS_STATUS: begin
          prdata_next[`NUM_ALM-1:0]              = alm_reg;
          prdata_next[`ST_EVT_BASE +: `NUM_EVT]  = evt_reg;
          prdata_next[`ST_OUT_BIT]               = out_on_reg;
          prdata_next[`ST_REJ_BIT]               = rej_reg;
        end
        `OFS_ACK, `OFS_PROFILE: ;
        default: pslverr_next = 1'b1;
      endcase
    end

    // A profile load replaces the whole event set, only with the output off.
    if (profile_load && cfg_ok) begin
      for (int i = 0; i < `NUM_EVT; i++) begin
        thr_next[i] = profile_thr[i];
        act_next[i] = supervisor_pkg::action_e'(profile_act[2*i +: 2]);
      end
    end

    // Latched flags: a new cause wins over an acknowledge in the same cycle.
    alm_next = (alm_reg & ~ack_a) | cause;
    evt_next = '0;
    for (int i = 0; i < `NUM_EVT; i++) begin
      evt_next[i] = (evt_reg[i] && !ack_e[i]) ||
                    (sample_valid && out_on_reg && evt_hit[i] &&
                     act_reg[i] != supervisor_pkg::ACT_NONE);
    end

    if (trip) begin
      // Remember whether the output was on for a possible automatic return.
      if (out_on_reg) resume_next = 1'b1;
      if (|cause[`ALM_WPROT:`ALM_VPROT] || |evt_alarm_hit) resume_next = 1'b0;
      out_on_next = 1'b0;
    end else if (resume_reg && !out_on_reg) begin
      // Causes are gone: return if every latched fault allows it, otherwise give up.
      // Giving up here keeps a later acknowledge from switching the output back on.
      resume_next = 1'b0;
      if ((!alm_reg[`ALM_PF] || pf_res_reg) && (!alm_reg[`ALM_OT] || ot_res_reg) &&
          alm_reg[`ALM_WPROT:`ALM_VPROT] == '0 && evt_alarm_hit == '0) begin
        out_on_next = 1'b1;
      end
    end else if (!out_on_reg && !resume_reg) begin
      resume_next = 1'b0;
    end

    text_next = |evt_next;
    warn_next = 1'b0;
    apop_next = |alm_next;
    beep_next = 1'b0;
    for (int i = 0; i < `NUM_EVT; i++) begin
      if (evt_next[i] && act_next[i] == supervisor_pkg::ACT_WARNING) warn_next = 1'b1;
      if (evt_next[i] && act_next[i] == supervisor_pkg::ACT_ALARM) apop_next = 1'b1;
    end
    beep_next = apop_next && sound_next;
    text_next = text_next || |alm_next;
    comb_next = |alm_next[`ALM_WPROT:`ALM_VPROT];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_on_reg     <= 1'b0;
      sound_reg      <= 1'b1;
      pf_res_reg     <= 1'b0;
      ot_res_reg     <= 1'b0;
      vprot_reg      <= VPROT_DEF;
      aprot_reg      <= APROT_DEF;
      wprot_reg      <= WPROT_DEF;
      for (int i = 0; i < `NUM_EVT; i++) begin
        thr_reg[i] <= '0;
        act_reg[i] <= supervisor_pkg::ACT_NONE;
      end
      alm_reg        <= '0;
      evt_reg        <= '0;
      resume_reg     <= 1'b0;
      rej_reg        <= 1'b0;
      level_reg      <= '0;
      prdata         <= `ZERO32;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      dc_output_on   <= 1'b0;
      status_text    <= 1'b0;
      warning_popup  <= 1'b0;
      alarm_popup    <= 1'b0;
      beep           <= 1'b0;
      combined_alarm <= 1'b0;
    end else begin
      out_on_reg     <= out_on_next;
      sound_reg      <= sound_next;
      pf_res_reg     <= pf_res_next;
      ot_res_reg     <= ot_res_next;
      vprot_reg      <= vprot_next;
      aprot_reg      <= aprot_next;
      wprot_reg      <= wprot_next;
      thr_reg        <= thr_next;
      act_reg        <= act_next;
      alm_reg        <= alm_next;
      evt_reg        <= evt_next;
      resume_reg     <= resume_next;
      rej_reg        <= rej_next;
      level_reg      <= level_next;
      prdata         <= prdata_next;
      pready         <= pready_next;
      pslverr        <= pslverr_next;
      dc_output_on   <= out_on_next;
      status_text    <= text_next;
      warning_popup  <= warn_next;
      alarm_popup    <= apop_next;
      beep           <= beep_next;
      combined_alarm <= comb_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  prot_trip_off_a : assert property (@(posedge pclk) disable iff (!presetn)
    (|cause) |=> !dc_output_on)
    else $error("Output still on after a protection cause.");

  volt_trip_a : assert property (@(posedge pclk) disable iff (!presetn)
    (sample_valid && meas_volt >= vprot_reg) |=> alm_reg[`ALM_VPROT] && alarm_popup)
    else $error("Voltage protection did not latch.");

  ack_blocked_a : assert property (@(posedge pclk) disable iff (!presetn)
    (alm_reg[`ALM_OT] && overheat_fault) |=> alm_reg[`ALM_OT])
    else $error("Overheat alarm cleared while its cause persists.");

  cfg_locked_a : assert property (@(posedge pclk) disable iff (!presetn)
    out_on_reg |=> $stable(vprot_reg) && $stable(aprot_reg) && $stable(sound_reg))
    else $error("Configuration changed while output on.");

  event_off_a : assert property (@(posedge pclk) disable iff (!presetn)
    (!out_on_reg && evt_reg == '0) |=> evt_reg == '0)
    else $error("Event latched while output off.");

  beep_sound_a : assert property (@(posedge pclk) disable iff (!presetn)
    beep |-> alarm_popup && sound_reg)
    else $error("Beep without alarm or with sound off.");

  combined_out_a : assert property (@(posedge pclk) disable iff (!presetn)
    combined_alarm == (alm_reg[`ALM_WPROT:`ALM_VPROT] != '0))
    else $error("Combined alarm output disagrees with latched alarms.");

  none_quiet_a : assert property (@(posedge pclk) disable iff (!presetn)
    (act_reg[`EVT_LOWV] == supervisor_pkg::ACT_NONE && !evt_reg[`EVT_LOWV] && !profile_load
     && !wr_acc) |=> !evt_reg[`EVT_LOWV])
    else $error("Disabled event latched.");

  hold_ind_a : assert property (@(posedge pclk) disable iff (!presetn)
    (alm_reg[`ALM_PF] && !wr_acc) |=> alm_reg[`ALM_PF])
    else $error("Supply alarm dropped without acknowledge.");

endmodule

/* verif/meas_source.sv */
// Measurement front end model that presents a new sample every fourth cycle.
`timescale 1ns/100ps

module meas_source (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] volt_set,
  input  wire logic [15:0] amp_set,
  input  wire logic [15:0] watt_set,
  output logic             sample_valid,
  output logic [15:0]      meas_volt,
  output logic [15:0]      meas_amp,
  output logic [15:0]      meas_watt
);
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  logic       fresh;

  always_comb begin
    phase_next = phase_reg + 2'h1;
    fresh = (phase_next == 2'h0);
  end

  // Between samples the lines carry inverted values, so stale data is never mistaken for valid.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 2'h0;
      sample_valid <= 1'b0;
      meas_volt <= 16'h0000;
      meas_amp <= 16'h0000;
      meas_watt <= 16'h0000;
    end else begin
      phase_reg <= phase_next;
      sample_valid <= fresh;
      meas_volt <= fresh ? volt_set : ~volt_set;
      meas_amp <= fresh ? amp_set : ~amp_set;
      meas_watt <= fresh ? watt_set : ~watt_set;
    end
  end
endmodule

/* verif/tb.sv */
// Self-checking bench for the output alarm and event supervisor.
`timescale 1ns/100ps
`include "supervisor_cfg.svh"

module tb;
  localparam int          NV = 16'h2000;
  localparam int          NA = 16'h1000;
  localparam int          NW = 16'h4000;
  localparam logic [31:0] VP = 32'(NV * 110 / 100);
  localparam logic [31:0] AP = 32'(NA * 110 / 100);
  localparam logic [31:0] WP = 32'(NW * 110 / 100);

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sample_valid;
  logic [15:0] meas_volt;
  logic [15:0] meas_amp;
  logic [15:0] meas_watt;
  logic [15:0] volt_set;
  logic [15:0] amp_set;
  logic [15:0] watt_set;
  logic        supply_fault;
  logic        overheat_fault;
  logic        profile_load;
  logic [15:0] profile_thr [`NUM_EVT];
  logic [9:0]  profile_act;
  logic        dc_output_on;
  logic        status_text;
  logic        warning_popup;
  logic        alarm_popup;
  logic        beep;
  logic        combined_alarm;
  logic [31:0] rd;
  logic        err;
  int          failures;
  int          cmp_count;

  output_alarm_event_supervisor #(.W(16), .NOM_V(NV), .NOM_A(NA), .NOM_W(NW))
    output_alarm_event_supervisor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .meas_volt(meas_volt),
    .meas_amp(meas_amp), .meas_watt(meas_watt), .supply_fault(supply_fault),
    .overheat_fault(overheat_fault), .profile_load(profile_load), .profile_thr(profile_thr),
    .profile_act(profile_act), .dc_output_on(dc_output_on), .status_text(status_text),
    .warning_popup(warning_popup), .alarm_popup(alarm_popup), .beep(beep),
    .combined_alarm(combined_alarm));

  meas_source meas_source_inst (.pclk(pclk), .presetn(presetn), .volt_set(volt_set),
    .amp_set(amp_set), .watt_set(watt_set), .sample_valid(sample_valid),
    .meas_volt(meas_volt), .meas_amp(meas_amp), .meas_watt(meas_watt));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h0000_0001, {31'h0, pready});
  endtask

  // Waits for n fresh samples taken after the last setting, then lets results settle.
  task automatic samples(input int n);
    int k;
    k = 0;
    @(posedge pclk);
    repeat (n) begin
      @(posedge pclk);
      while (sample_valid !== 1'b1 && k < 100) begin
        @(posedge pclk);
        k++;
      end
    end
    chk("sample timeout", 32'h0, {31'h0, (k >= 100)});
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic set_meas(input logic [15:0] v, input logic [15:0] a, input logic [15:0] w);
    volt_set <= v;
    amp_set <= a;
    watt_set <= w;
  endtask

  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(0, `OFS_VPROT, 32'h0);
    chk("vprot reset", VP, rd);
    apb(0, `OFS_APROT, 32'h0);
    chk("aprot reset", AP, rd);
    apb(0, `OFS_WPROT, 32'h0);
    chk("wprot reset", WP, rd);
    apb(1, `OFS_VPROT, 32'h0000_2300);
    apb(0, `OFS_VPROT, 32'h0);
    chk("vprot adjust", 32'h0000_2300, rd);
    apb(1, `OFS_VPROT, VP);
    apb(0, `OFS_ACTIONS, 32'h0);
    chk("actions reset", 32'h0, rd);
    apb(0, `OFS_STATUS, 32'h0);
    chk("status reset", 32'h0, rd);
    apb(0, 12'h040, 32'h0);
    chk("unmapped slverr", 32'h0000_0001, {31'h0, err});
  endtask

  task automatic t_events;
    apb(1, `OFS_LOWV_THR, 32'h0000_1800);
    apb(1, `OFS_HIGHV_THR, 32'h0000_1000);
    apb(1, `OFS_LOWA_THR, 32'h0000_0800);
    apb(1, `OFS_HIGHA_THR, 32'h0000_0C00);
    apb(1, `OFS_HIGHW_THR, 32'h0000_3000);
    apb(1, `OFS_ACTIONS, 32'h0000_00E4);
    apb(0, `OFS_ACTIONS, 32'h0);
    chk("actions", 32'h0000_00E4, rd);
    set_meas(16'h1100, 16'h0A00, 16'h0000);
    samples(2);
    chk("text while off", 32'h0, {31'h0, status_text});
    apb(1, `OFS_CTRL, 32'h0000_0003);
    samples(2);
    chk("output on", 32'h1, {31'h0, dc_output_on});
    chk("signal text", 32'h1, {31'h0, status_text});
    chk("signal no popup", 32'h0, {31'h0, warning_popup});
    apb(0, `OFS_STATUS, 32'h0);
    chk("event bits", 32'h0001_0200, rd & 32'h0001_1F1F);
    apb(1, `OFS_HIGHV_THR, 32'h0000_0100);
    apb(0, `OFS_HIGHV_THR, 32'h0);
    chk("locked threshold", 32'h0000_1000, rd);
    apb(0, `OFS_STATUS, 32'h0);
    chk("rejected flag", 32'h1, {31'h0, rd[`ST_REJ_BIT]});
    set_meas(16'h1100, 16'h0700, 16'h0000);
    samples(1);
    chk("warning popup", 32'h1, {31'h0, warning_popup});
    set_meas(16'h1100, 16'h0D00, 16'h0000);
    samples(1);
    chk("alarm popup", 32'h1, {31'h0, alarm_popup});
    chk("alarm beep", 32'h1, {31'h0, beep});
    chk("alarm output off", 32'h0, {31'h0, dc_output_on});
    chk("event not combined", 32'h0, {31'h0, combined_alarm});
    set_meas(16'h0800, 16'h0A00, 16'h0000);
    apb(1, `OFS_ACTIONS, 32'h0);
    apb(1, `OFS_ACK, 32'h0000_1F1F);
    samples(1);
    chk("event ack", 32'h0, {31'h0, alarm_popup});
  endtask

  task automatic t_protect;
    logic [15:0] lim [3];
    lim = '{VP[15:0], AP[15:0], WP[15:0]};
    for (int i = 0; i < 3; i++) begin
      apb(1, `OFS_CTRL, 32'h0000_0003);
      set_meas(i == 0 ? lim[i] - 16'h1 : 16'h0800, i == 1 ? lim[i] - 16'h1 : 16'h0A00,
               i == 2 ? lim[i] - 16'h1 : 16'h0000);
      samples(2);
      chk("below limit", 32'h1, {31'h0, dc_output_on});
      set_meas(i == 0 ? lim[i] : 16'h0800, i == 1 ? lim[i] : 16'h0A00,
               i == 2 ? lim[i] : 16'h0000);
      samples(1);
      chk("trip off", 32'h0, {31'h0, dc_output_on});
      chk("combined high", 32'h1, {31'h0, combined_alarm});
      apb(1, `OFS_ACK, 32'h1 << i);
      apb(0, `OFS_STATUS, 32'h0);
      chk("ack with cause", 32'h1, {31'h0, rd[i]});
      set_meas(16'h0800, 16'h0A00, 16'h0000);
      samples(1);
      apb(1, `OFS_ACK, 32'h1 << i);
      apb(0, `OFS_STATUS, 32'h0);
      chk("ack cleared", 32'h0, {31'h0, rd[i]});
      chk("combined low", 32'h0, {31'h0, combined_alarm});
    end
  endtask

  task automatic t_fault;
    apb(1, `OFS_CTRL, 32'h0000_0007);
    samples(1);
    @(posedge pclk);
    supply_fault <= 1'b1;
    samples(1);
    chk("supply fail off", 32'h0, {31'h0, dc_output_on});
    chk("supply not combined", 32'h0, {31'h0, combined_alarm});
    @(posedge pclk);
    supply_fault <= 1'b0;
    samples(1);
    chk("auto resume", 32'h1, {31'h0, dc_output_on});
    chk("popup kept", 32'h1, {31'h0, alarm_popup});
    apb(1, `OFS_ACK, 32'h1 << `ALM_PF);
    samples(1);
    chk("popup acked", 32'h0, {31'h0, alarm_popup});
    apb(1, `OFS_CTRL, 32'h0000_0012);
    apb(1, `OFS_CTRL, 32'h0000_0003);
    @(posedge pclk);
    overheat_fault <= 1'b1;
    samples(1);
    chk("overheat off", 32'h0, {31'h0, dc_output_on});
    apb(1, `OFS_ACK, 32'h1 << `ALM_OT);
    apb(0, `OFS_STATUS, 32'h0);
    chk("overheat latched", 32'h1, {31'h0, rd[`ALM_OT]});
    @(posedge pclk);
    overheat_fault <= 1'b0;
    samples(2);
    chk("no resume", 32'h0, {31'h0, dc_output_on});
    apb(1, `OFS_ACK, 32'h1 << `ALM_OT);
    samples(1);
    chk("stays off after ack", 32'h0, {31'h0, dc_output_on});
  endtask

  task automatic t_profile;
    @(posedge pclk);
    for (int k = 0; k < 5; k++)
      profile_thr[k] <= 16'h0111 * 16'(k + 1);
    profile_act <= 10'h2B9;
    profile_load <= 1'b1;
    @(posedge pclk);
    profile_load <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      apb(0, 12'(`OFS_LOWV_THR + 4 * k), 32'h0);
      chk("profile threshold", 32'(16'h0111 * 16'(k + 1)), rd);
    end
    apb(0, `OFS_ACTIONS, 32'h0);
    chk("profile actions", 32'h0000_02B9, rd);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  initial begin
    #2_000_000;
    failures++;
    summarize();
  end

  initial begin
    failures = 0;
    cmp_count = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {supply_fault, overheat_fault, profile_load, profile_act} = '0;
    for (int k = 0; k < 5; k++)
      profile_thr[k] = 16'h0000;
    set_meas(16'h0800, 16'h0A00, 16'h0000);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_events();
    t_protect();
    t_fault();
    t_profile();
    summarize();
  end
endmodule
